// ### hw/i2m_master.sv
// Two-wire bus master with general call and address recognition
`timescale 1ns/1ps
`default_nettype none
module i2m_master (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port
	input wire i2m_pkg::i2m_bus_s bus,
	output logic [15:0] rdata,
	// Bus pins, oe low drives the line low
	input wire logic sclIn,
	input wire logic sdaIn,
	output i2m_pkg::i2m_pins_s pins,
	output logic slopeControlDisable,
	// Interrupt
	output logic irq
);
	import i2m_pkg::*;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [6:0] own;
		logic [15:0] baud;
		logic [15:0] cnt;
		logic [7:0] txData;
		logic [7:0] shift;
		logic [7:0] scanSh;
		logic [7:0] rxBuf;
		logic [3:0] bitCnt;
		logic [3:0] scanCnt;
		logic [1:0] phase;
		logic txFull;
		logic rxFull;
		logic ackIn;
		logic txProg;
		logic gcStat;
		logic busy;
		logic addrPhase;
		logic [1:0] irqStat;
		logic [1:0] irqMask;
		logic [15:0] rdata;
		logic sclOe;
		logic sdaOe;
		logic slope;
		logic irq;
		logic [1:0] sclS;
		logic [1:0] sdaS;
		logic sclLast;
		logic sdaLast;
		logic sScan;
		i2m_state_e st;
	} i2m_reg_s;

	i2m_reg_s r;
	i2m_reg_s next_r;
	logic tick;
	logic sclF;
	logic sdaF;
	logic [1:0] setEv;
	logic rxSet;
	logic [15:0] statWord;

	assign sclF = r.sclS[1];
	assign sdaF = r.sdaS[1];
	// Baud rollover
	assign tick = (r.cnt == 16'h0000);

	always_comb begin
		statWord = 16'h0000;
		statWord[S_ACKIN] = r.ackIn;
		statWord[S_TXPROG] = r.txProg;
		statWord[S_GCSTAT] = r.gcStat;
		statWord[S_BUSY] = r.busy;
		statWord[S_RXFULL] = r.rxFull;
		statWord[S_TXFULL] = r.txFull;
	end

	always_comb begin
		next_r = r;
		setEv = 2'b00;
		rxSet = 1'b0;
		next_r.sclS = {r.sclS[0], sclIn};
		next_r.sdaS = {r.sdaS[0], sdaIn};
		next_r.sclLast = sclF;
		next_r.sdaLast = sdaF;
		//--------------------------------------------------------------
		// Baud rate generator
		//--------------------------------------------------------------
		// reload from divisor
		if (r.st == ST_IDLE || r.st == ST_WAIT || tick) begin
			next_r.cnt = r.baud;
		end else begin
			next_r.cnt = r.cnt - 16'h0001;
		end
		//--------------------------------------------------------------
		// Slave side address scan
		//--------------------------------------------------------------
		// Own counter and shifter: the watcher also sees our own
		// master traffic and must not disturb the master bit count
		if (r.sclLast && sclF && r.sdaLast && !sdaF) begin
			next_r.sScan = 1'b1;
			next_r.addrPhase = 1'b1;
			next_r.scanCnt = 4'h0;
		end
		if (r.sScan && !r.sclLast && sclF && r.st != ST_RX) begin
			next_r.scanSh = {r.scanSh[6:0], sdaF};
			next_r.scanCnt = r.scanCnt + 4'h1;
		end
		if (r.sScan && r.sclLast && !sclF && r.scanCnt == BITS_PER_BYTE) begin
			next_r.sScan = 1'b0;
			next_r.addrPhase = 1'b0;
			if (r.ctrl[C_GCALL] && r.scanSh == GCALL_BYTE) begin
				next_r.rxBuf = r.scanSh;
				next_r.rxFull = 1'b1;
				rxSet = 1'b1;
				next_r.gcStat = 1'b1;
				next_r.busy = 1'b1;
			end else if (r.ctrl[C_ACCALL] || r.scanSh[7:1] == r.own) begin
				setEv[I_SLAVE] = 1'b1;
				next_r.gcStat = 1'b0;
			end
		end
		// master flag on ninth falling edge
		if (r.gcStat && r.busy && !r.sScan && r.scanCnt == BITS_PER_BYTE &&
				!r.sclLast && sclF) begin
			next_r.scanCnt = BITS_PER_BYTE + 4'h1;
		end
		if (r.gcStat && r.busy && r.scanCnt == BITS_PER_BYTE + 4'h1 &&
				r.sclLast && !sclF) begin
			setEv[I_MASTER] = 1'b1;
			next_r.busy = 1'b0;
		end
		//--------------------------------------------------------------
		// Master sequencer
		//--------------------------------------------------------------
		unique case (r.st)
			ST_IDLE, ST_WAIT: begin
				next_r.phase = 2'd0;
			end
			ST_START, ST_RSTART: begin
				if (tick) begin
					next_r.phase = r.phase + 2'd1;
					if (r.phase == 2'd0) begin
						next_r.sdaOe = 1'b1;
						next_r.sclOe = 1'b1;
					end else if (r.phase == 2'd1) begin
						next_r.sdaOe = 1'b0;
					end else begin
						// bus kept claimed, clock held low
						next_r.sclOe = 1'b0;
						next_r.st = ST_WAIT;
						next_r.ctrl[C_START] = 1'b0;
						next_r.ctrl[C_RSTART] = 1'b0;
						setEv[I_MASTER] = 1'b1;
					end
				end
			end
			ST_STOP: begin
				if (tick) begin
					next_r.phase = r.phase + 2'd1;
					if (r.phase == 2'd0) begin
						next_r.sdaOe = 1'b0;
					end else if (r.phase == 2'd1) begin
						next_r.sclOe = 1'b1;
					end else begin
						next_r.sdaOe = 1'b1;
						next_r.st = ST_IDLE;
						next_r.ctrl[C_STOP] = 1'b0;
						setEv[I_MASTER] = 1'b1;
					end
				end
			end
			ST_TX: begin
				if (tick) begin
					if (!r.sclOe) begin
						if (r.phase == 2'd0) begin
							next_r.sdaOe = r.txData[3'd7 - r.bitCnt[2:0]];
							next_r.phase = 2'd1;
						end else begin
							next_r.sclOe = 1'b1;
							next_r.phase = 2'd0;
						end
					end else begin
						next_r.sclOe = 1'b0;
						next_r.bitCnt = r.bitCnt + 4'h1;
						if (r.bitCnt == BITS_PER_BYTE - 4'h1) begin
							next_r.sdaOe = 1'b1;
							next_r.st = ST_TXACK;
						end
					end
				end
			end
			ST_TXACK: begin
				if (tick) begin
					if (!r.sclOe) begin
						next_r.sclOe = 1'b1;
					end else begin
						next_r.ackIn = sdaF;
						next_r.sclOe = 1'b0;
						next_r.txProg = 1'b0;
						next_r.txFull = 1'b0;
						next_r.st = ST_WAIT;
						setEv[I_MASTER] = 1'b1;
					end
				end
			end
			// toggle on rollover, sample on rise
			ST_RX: begin
				if (tick) begin
					next_r.sclOe = !r.sclOe;
					if (!r.sclOe) begin
						next_r.shift = {r.shift[6:0], sdaF};
						next_r.bitCnt = r.bitCnt + 4'h1;
					end else if (r.bitCnt == BITS_PER_BYTE) begin
						next_r.rxBuf = r.shift;
						next_r.rxFull = 1'b1;
						rxSet = 1'b1;
						next_r.ctrl[C_RECV] = 1'b0;
						next_r.st = ST_WAIT;
						setEv[I_MASTER] = 1'b1;
					end
				end
			end
			ST_ACKOUT: begin
				if (tick) begin
					next_r.phase = r.phase + 2'd1;
					if (r.phase == 2'd0) begin
						next_r.sdaOe = r.ctrl[C_ACKDT];
					end else if (r.phase == 2'd1) begin
						next_r.sclOe = 1'b1;
					end else begin
						next_r.sclOe = 1'b0;
						next_r.sdaOe = 1'b1;
						next_r.ctrl[C_ACK] = 1'b0;
						next_r.st = ST_WAIT;
						setEv[I_MASTER] = 1'b1;
					end
				end
			end
		endcase
		//--------------------------------------------------------------
		// Register writes
		//--------------------------------------------------------------
		if (bus.wr) begin
			unique case (bus.addr)
				OFS_CTRL: begin
					next_r.ctrl[C_EN] = bus.wdata[C_EN];
					next_r.ctrl[C_ACKDT] = bus.wdata[C_ACKDT];
					next_r.ctrl[C_ACCALL] = bus.wdata[C_ACCALL];
					next_r.ctrl[C_GCALL] = bus.wdata[C_GCALL];
					next_r.ctrl[C_SLOPE] = bus.wdata[C_SLOPE];
					if (r.st == ST_IDLE || r.st == ST_WAIT) begin
						if (bus.wdata[C_START] && r.st == ST_IDLE) begin
							next_r.ctrl[C_START] = 1'b1;
							next_r.st = ST_START;
						end else if (bus.wdata[C_RSTART] && r.st == ST_WAIT) begin
							next_r.ctrl[C_RSTART] = 1'b1;
							next_r.st = ST_RSTART;
						end else if (bus.wdata[C_STOP] && r.st == ST_WAIT) begin
							next_r.ctrl[C_STOP] = 1'b1;
							next_r.st = ST_STOP;
						end else if (bus.wdata[C_RECV] && r.st == ST_WAIT) begin
							next_r.ctrl[C_RECV] = 1'b1;
							next_r.bitCnt = 4'h0;
							next_r.sdaOe = 1'b1;
							next_r.st = ST_RX;
						end else if (bus.wdata[C_ACK] && r.st == ST_WAIT) begin
							next_r.ctrl[C_ACK] = 1'b1;
							next_r.st = ST_ACKOUT;
						end
					end
				end
				OFS_TX: begin
					next_r.txData = bus.wdata[7:0];
					if (r.st == ST_WAIT) begin
						next_r.txFull = 1'b1;
						next_r.txProg = 1'b1;
						next_r.bitCnt = 4'h0;
						next_r.st = ST_TX;
					end
				end
				OFS_OWN: next_r.own = bus.wdata[6:0];
				OFS_BAUD: next_r.baud = bus.wdata;
				OFS_MASK: next_r.irqMask = bus.wdata[1:0];
				OFS_IRQ: next_r.irqStat = r.irqStat & ~bus.wdata[1:0];
				default: begin
				end
			endcase
		end
		// events set sticky flags, set beats clear
		next_r.irqStat = next_r.irqStat | setEv;
		next_r.irq = |(next_r.irqStat & next_r.irqMask);
		//--------------------------------------------------------------
		// Register reads, data one cycle later
		//--------------------------------------------------------------
		next_r.rdata = 16'h0000;
		if (bus.rd) begin
			unique case (bus.addr)
				OFS_CTRL: next_r.rdata = r.ctrl;
				OFS_STAT: next_r.rdata = statWord;
				OFS_TX: next_r.rdata = {8'h00, r.txData};
				OFS_RX: begin
					next_r.rdata = {8'h00, r.rxBuf};
					// A byte landing during the read wins over the clear
					if (!rxSet) begin
						next_r.rxFull = 1'b0;
					end
				end
				OFS_OWN: next_r.rdata = {9'h000, r.own};
				OFS_BAUD: next_r.rdata = r.baud;
				OFS_IRQ: next_r.rdata = {14'h0000, r.irqStat};
				OFS_MASK: next_r.rdata = {14'h0000, r.irqMask};
				default: next_r.rdata = 16'h0000;
			endcase
		end
		next_r.slope = next_r.ctrl[C_SLOPE];
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r <= '0;
			r.baud <= BAUD_RST;
			r.own <= OWN_RST;
			r.sclOe <= 1'b1;
			r.sdaOe <= 1'b1;
			r.sclS <= 2'b11;
			r.sdaS <= 2'b11;
			r.sclLast <= 1'b1;
			r.sdaLast <= 1'b1;
			r.st <= ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign rdata = r.rdata;
	assign pins = '{sclOe: r.sclOe, sdaOe: r.sdaOe};
	assign slopeControlDisable = r.slope;
	assign irq = r.irq;

	rx_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(bus.wr && bus.addr == OFS_CTRL && bus.wdata[C_RECV] && r.st != ST_WAIT &&
		 r.st != ST_RX) |=> r.st != ST_RX) else $error("receive started while busy");
	tx_status_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(r.st == ST_TX) |-> r.txProg) else $error("transmit status low in transmit");
	stop_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(r.st == ST_STOP && $past(r.st) == ST_STOP && $changed(r.st) == 1'b0 &&
		 next_r.st == ST_IDLE) |=> r.irqStat[I_MASTER]) else $error("no flag after stop");
	// receive enable cleared with full flag
	rx_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
		($past(r.st) == ST_RX && r.st == ST_WAIT) |-> (r.rxFull && !r.ctrl[C_RECV]))
		else $error("receive completion incomplete");
	irq_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
		r.irq == |(r.irqStat & r.irqMask)) else $error("interrupt line out of step");
	// data moves only while clock is low
	tx_data_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(r.st == ST_TX && $changed(r.sdaOe)) |-> (!r.sclOe && !$past(r.sclOe)))
		else $error("data changed with clock released");
endmodule : i2m_master
`default_nettype wire

// ### inc/i2m_pkg.sv
// Constants, register map and types for the two-wire master block
//--------------------------------------------------------------
// How it works
// - Master event flag sets when a master-initiated start, stop, byte or ack completes.
// - Slave event flag sets when an address matching this device is seen.
// - Control bit disables slope control; needed off for 1 MHz operation.
// - Accept-all-addresses enable makes every received address a match.
// - General call (all-zero byte, write) matches only while control bit 7 set.
// - After a start, eight bits shift in and compare with own and general call.
// - General call match loads receive buffer, sets full, master flag on ninth fall.
// - Master supports start, restart, stop, transmit, receive and acknowledge generation.
// - Master drives all clock pulses; restart keeps the bus claimed.
// - Master transmit sends address with direction 0, 8-bit bytes, receiver acknowledges.
// - Master receive sends address with direction 1, master acknowledges each byte.
// - Transmit write in ST_WAIT sets transmit full, starts baud generator and shifting; in other states it only loads the data.
// - Each transmitted bit changes data after the clock falling edge.
// - Status bit 14 reads high while a master transmission runs.
// - Receive enable bit 3 starts reception only while holding the bus in ST_WAIT, else ignored (also in ST_IDLE).
// - Baud generator rolls over to toggle clock; data sampled on rising edges.
//--------------------------------------------------------------
package i2m_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STAT = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_TX = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_RX = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_OWN = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_BAUD = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_IRQ = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_MASK = 4'h7;
	// Control bit positions
	localparam int C_START = 0;
	localparam int C_RSTART = 1;
	localparam int C_STOP = 2;
	localparam int C_RECV = 3;
	localparam int C_ACK = 4;
	localparam int C_ACKDT = 5;
	localparam int C_ACCALL = 6;
	localparam int C_GCALL = 7;
	localparam int C_SLOPE = 9;
	localparam int C_EN = 15;
	// Status bit positions
	localparam int S_RXFULL = 1;
	localparam int S_TXFULL = 0;
	localparam int S_ACKIN = 15;
	localparam int S_TXPROG = 14;
	localparam int S_GCSTAT = 9;
	localparam int S_BUSY = 4;
	// Interrupt status bits
	localparam int I_MASTER = 0;
	localparam int I_SLAVE = 1;
	localparam logic [15:0] BAUD_RST = 16'h0009;
	localparam logic [6:0] OWN_RST = 7'h00;
	localparam logic [7:0] GCALL_BYTE = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE, ST_START, ST_RSTART, ST_STOP, ST_TX, ST_TXACK,
		ST_RX, ST_ACKOUT, ST_WAIT
	} i2m_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} i2m_bus_s;

	typedef struct packed {
		logic sclOe;
		logic sdaOe;
	} i2m_pins_s;
endpackage : i2m_pkg

// ### verif/i2m_master_tb.sv
// Self-checking bench for the two-wire master block
`timescale 1ns/1ps
`default_nettype none
module i2m_master_tb;
	import i2m_pkg::*;
	localparam logic [15:0] EN = 16'h8000;
	logic mclk, rst_b, sclIn, sdaIn, slopeDis, irq, sdaRel, stopSeen, tbScl, tbSda, sclPrev;
	logic [15:0] rdata, rv, mk;
	logic [7:0] lastByte;
	i2m_bus_s bus;
	i2m_pins_s pins;
	int error_cnt, checks_done, cyc, lastRise, per, p1, p2;
	assign sclIn = pins.sclOe & tbScl;
	assign sdaIn = pins.sdaOe & sdaRel & tbSda;
	i2m_master i_dut (.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .sclIn(sclIn),
		.sdaIn(sdaIn), .pins(pins), .slopeControlDisable(slopeDis), .irq(irq));
	i2m_slave_model i_slave (.mclk(mclk), .scl(sclIn), .sda(sdaIn), .sdaRel(sdaRel),
		.lastByte(lastByte), .stopSeen(stopSeen));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Clock period watch and hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		sclPrev <= sclIn;
		if (sclIn && !sclPrev) begin
			per <= cyc - lastRise;
			lastRise <= cyc;
		end
		if (cyc == 80000) begin
			error_cnt++;
			results();
		end
	end
	task automatic results;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Write strobe stays up until the next task, so back-to-back writes need no gap
	task automatic hold(input int n);
		if (bus.wr)
			bus.wr <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask : hold
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge mclk);
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		bus.addr <= a;
		bus.wr <= 1'b0;
		bus.rd <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd
	// Poll the event status, judge the interrupt line, then clear
	task automatic flag(input logic [15:0] cm, input logic [15:0] e);
		int n;
		rv = 16'h0;
		for (n = 0; n < ((e != 16'h0) ? 3000 : 1) && (rv & cm) == 16'h0; n++)
			rd(OFS_IRQ, rv);
		chk(rv & cm, e);
		chk({15'h0, irq}, {15'h0, |(rv & mk)});
		wr(OFS_IRQ, 16'h3);
		rd(OFS_IRQ, rv);
		chk({13'h0, rv[1:0], irq}, 16'h0);
	endtask : flag
	task automatic t_write(input logic [6:0] a, input logic [7:0] d, input logic [15:0] bd,
		input logic [15:0] m, output int p);
		mk = m;
		wr(OFS_MASK, m);
		wr(OFS_BAUD, bd);
		wr(OFS_CTRL, EN | 16'h1);
		flag(16'h1, 16'h1);
		wr(OFS_TX, {8'h0, a, 1'b0});
		rd(OFS_STAT, rv);
		chk(rv & 16'h4001, 16'h4001);
		flag(16'h1, 16'h1);
		chk({8'h0, lastByte}, {8'h0, a, 1'b0});
		wr(OFS_TX, {8'h0, d});
		flag(16'h1, 16'h1);
		p = per;
		rd(OFS_STAT, rv);
		chk(rv & 16'hc000, 16'h0);
		chk({8'h0, lastByte}, {8'h0, d});
		wr(OFS_CTRL, EN | 16'h4);
		flag(16'h1, 16'h1);
		chk({15'h0, stopSeen}, 16'h1);
	endtask : t_write
	task automatic t_read;
		wr(OFS_CTRL, EN | 16'h8);
		rd(OFS_CTRL, rv);
		chk(rv & 16'h8, 16'h0);
		wr(OFS_CTRL, EN | 16'h1);
		flag(16'h1, 16'h1);
		wr(OFS_TX, {8'h0, 7'h51, 1'b1});
		flag(16'h1, 16'h1);
		wr(OFS_CTRL, EN | 16'h8);
		flag(16'h1, 16'h1);
		rd(OFS_CTRL, rv);
		chk(rv & 16'h8, 16'h0);
		rd(OFS_STAT, rv);
		chk(rv & 16'h2, 16'h2);
		rd(OFS_RX, rv);
		chk(rv & 16'hff, 16'hc5);
		wr(OFS_CTRL, EN | 16'h10);
		flag(16'h1, 16'h1);
		wr(OFS_CTRL, EN | 16'h4);
		flag(16'h1, 16'h1);
	endtask : t_read
	// Another master on the wire: start, one byte, idle ninth bit, stop
	task automatic t_slave(input logic [7:0] b, input logic [15:0] c, input logic [15:0] cm,
		input logic [15:0] e);
		int i;
		wr(OFS_OWN, 16'h2a);
		wr(OFS_CTRL, EN | c);
		tbSda <= 1'b0;
		hold(20);
		tbScl <= 1'b0;
		for (i = 8; i >= 0; i--) begin
			tbSda <= (i == 0) ? 1'b1 : b[i-1];
			hold(20);
			tbScl <= 1'b1;
			hold(20);
			tbScl <= 1'b0;
		end
		tbSda <= 1'b0;
		hold(20);
		tbScl <= 1'b1;
		hold(20);
		tbSda <= 1'b1;
		hold(20);
		flag(cm, e);
	endtask : t_slave
	initial begin
		rst_b = 1'b0;
		bus = '0;
		tbScl = 1'b1;
		tbSda = 1'b1;
		sclPrev = 1'b1;
		mk = 16'h3;
		error_cnt = 0;
		checks_done = 0;
		cyc = 0;
		lastRise = 0;
		per = 0;
		hold(16);
		rst_b <= 1'b1;
		hold(1);
		#1;
		chk({12'h0, pins, irq, slopeDis}, 16'hc);
		rd(OFS_BAUD, rv);
		chk(rv, BAUD_RST);
		rd(OFS_OWN, rv);
		chk(rv, {9'h0, OWN_RST});
		rd(4'hf, rv);
		chk(rv, 16'h0);
		wr(OFS_CTRL, 16'h200);
		hold(1);
		#1;
		chk({15'h0, slopeDis}, 16'h1);
		t_write(7'h51, 8'h96, 16'h3, 16'h0, p1);
		t_write(7'h51, 8'h3c, 16'h9, 16'h3, p2);
		chk(16'(p2 - p1), 16'hc);
		t_read();
		t_slave(8'h00, 16'h0, 16'h3, 16'h0);
		t_slave(8'h00, 16'h80, 16'h1, 16'h1);
		rd(OFS_STAT, rv);
		chk(rv & 16'h202, 16'h202);
		rd(OFS_RX, rv);
		chk(rv & 16'hff, 16'h0);
		t_slave(8'h54, 16'h0, 16'h2, 16'h2);
		t_slave(8'ha6, 16'h40, 16'h2, 16'h2);
		results();
	end
endmodule : i2m_master_tb
`default_nettype wire

// ### verif/i2m_slave_model.sv
// Behavioural two-wire slave that answers at one address
`timescale 1ns/1ps
`default_nettype none
module i2m_slave_model #(
	parameter logic [6:0] ADDR = 7'h51,
	parameter logic [7:0] TX_BYTE = 8'hc5
) (
	// Clock and resolved lines
	input wire logic mclk,
	input wire logic scl,
	input wire logic sda,
	// Open-drain data, low pulls the line down
	output logic sdaRel,
	output logic [7:0] lastByte,
	output logic stopSeen
);
	logic sclQ = 1'b1;
	logic sdaQ = 1'b1;
	logic sel = 1'b0;
	logic rdMode = 1'b0;
	logic addrPh = 1'b0;
	logic inAck = 1'b0;
	logic ackRose = 1'b0;
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h0;
	initial begin
		sdaRel = 1'b1;
		lastByte = 8'h0;
		stopSeen = 1'b0;
	end
	// Lines are sampled at the fast clock, so edges are seen at most one cycle late
	always @(posedge mclk) begin
		sclQ <= scl;
		sdaQ <= sda;
		if (scl && sclQ && sdaQ && !sda) begin
			cnt <= 4'h0;
			addrPh <= 1'b1;
			inAck <= 1'b0;
			ackRose <= 1'b0;
			sdaRel <= 1'b1;
			stopSeen <= 1'b0;
		end else if (scl && sclQ && !sdaQ && sda) begin
			sel <= 1'b0;
			stopSeen <= 1'b1;
			sdaRel <= 1'b1;
		end else if (scl && !sclQ) begin
			if (inAck)
				ackRose <= 1'b1;
			else if (cnt < 4'h8) begin
				sh <= {sh[6:0], sda};
				cnt <= cnt + 4'h1;
			end
		end else if (!scl && sclQ) begin
			if (inAck && ackRose) begin
				inAck <= 1'b0;
				ackRose <= 1'b0;
				cnt <= 4'h0;
				addrPh <= 1'b0;
				sdaRel <= !(sel && rdMode) || TX_BYTE[7];
			end else if (cnt == 4'h8 && !inAck) begin
				inAck <= 1'b1;
				lastByte <= sh;
				if (addrPh) begin
					sel <= sh[7:1] == ADDR;
					rdMode <= sh[0];
					sdaRel <= sh[7:1] != ADDR;
				end else
					sdaRel <= !sel || rdMode;
			end else if (sel && rdMode && !addrPh && cnt != 4'h0)
				sdaRel <= TX_BYTE[3'(4'h7 - cnt)];
		end
	end
endmodule : i2m_slave_model
`default_nettype wire
